// ---- verilog/smbt_ctrl.sv ----
// asynchronous static memory sequencer driven by per-bank timing halves
// assumes ref_clk is the memory clock and requests come from ref_clk logic
//
// Notes on behaviour
// - first delay codes 0-11 literal; 12..15 become 13, 15, 18, 23
// - first read of non-variable-latency devices: address to data is first+2
// - later reads of non-burst devices: address to data is first+1
// - flash writes hold write strobe low for first+1 clocks
// - variable-latency strobes last at least first+1 clocks per beat
// - width bit: 0 is 32-bit bus, 1 is 16-bit; software keeps it fixed
// - type field: 0 nonburst, 1 sram, 2 burst4, 3 burst8, 4 variable io
// - burst-of-four changes only the two low non-byte address bits
// - burst-of-eight changes three low bits; writes are single accesses
// - burst roms use first delay on the first beat of each group, next delay afterwards
// - recovery field spaces accesses; software sets it from turn-off time
// - bank 0 uses low half of the first word; odd banks use upper halves
// - chip select stays high twice the recovery value before reassertion
// - later burst beats within a group: address to data is next delay plus one
// - ready input passes a two-stage synchroniser before use
// - fully masked write beat keeps write strobe high, select asserted
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module smbt_ctrl
	import smbt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire smbt_req_t req,
	output logic req_ready,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic [25:0] memory_address_bus,
	output logic [5:0] bank_select_n,
	output logic output_enable_n,
	output logic write_enable_n,
	output logic io_write_enable_n,
	output logic [3:0] byte_mask_n,
	output logic [31:0] mem_data_o,
	output logic mem_data_oe,
	input wire logic [31:0] mem_data_i,
	input wire logic io_ready,
	input wire logic width_strap
);
	// ************************************************
	// declarations
	// ************************************************
	// register side and latched request
	logic [SMBT_NUM_PAIRS-1:0][31:0] cfg_words;
	logic [31:0] status_word;
	logic [31:0] pair_word;
	smbt_half_t req_half;
	smbt_half_t cfg_q;
	smbt_state_t state_q;
	logic [4:0] cnt_q;
	logic [2:0] beats_left_q;
	logic [2:0] beat_idx_q;
	logic write_q;
	logic [2:0] bank_q;
	logic [25:0] addr_q;
	logic [3:0] mask_q;
	logic [31:0] wdata_q;
	// pin-side flops; the address, mask and write data outputs use the latched request flops
	logic ready_q;
	logic rd_valid_q;
	logic [31:0] rd_data_q;
	logic [5:0] cs_n_q;
	logic oe_n_q;
	logic we_n_q;
	logic iowe_n_q;
	logic data_oe_q;
	// ready synchroniser pair
	logic rdy_meta_q;
	logic rdy_sync_q;
	// decode wires
	logic accept;
	logic [4:0] first_eff;
	logic [4:0] next_eff;
	logic [4:0] recov_cnt;
	logic is_var;
	logic is_burst4;
	logic is_burst8;
	logic [2:0] beat_nxt;
	logic group_start;
	logic [4:0] beat_cnt;
	logic strobe_done;
	logic last_beat;
	logic [25:0] addr_step;
	logic [25:0] addr_wrap;
	logic [25:0] addr_next;
	logic [5:0] cs_sel_n;
	logic write_masked;

	// ************************************************
	// configuration registers
	// ************************************************
	smbt_cfg_regs u_regs (
		.ref_clk(ref_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.status_word(status_word),
		.width_strap(width_strap),
		.reg_rdata(reg_rdata),
		.cfg_words(cfg_words)
	);

	// status shows the sequencer itself: busy, state, beats still to go
	assign status_word = {21'h00_0000, ~ready_q, state_q,
		beat_idx_q, beats_left_q, 1'b0};

	// ************************************************
	// bank half selection
	// ************************************************
	// banks 6 and 7 do not exist; they fall onto the last pair
	assign pair_word = (req.bank[2:1] == 2'h0) ? cfg_words[0] :
		(req.bank[2:1] == 2'h1) ? cfg_words[1] :
		cfg_words[2];
	assign req_half = req.bank[0] ?
		pair_word[31:16] : pair_word[15:0];
	// a request is taken only while idle and ready
	assign accept = req_valid && ready_q;

	// ************************************************
	// latched timing decode
	// ************************************************
	// decoded only from the latched half so a write mid-access cannot skew it
	assign first_eff = smbt_first_delay(cfg_q.first_delay);
	// the next delay is taken literally; only the first delay stretches
	assign next_eff = {1'b0, cfg_q.next_delay};
	// recovery counts in pairs of memory clocks
	assign recov_cnt = {1'b0, cfg_q.recovery, 1'b0};
	assign is_var = (cfg_q.mem_type == SMBT_TYPE_VARIO);
	assign is_burst4 = (cfg_q.mem_type == SMBT_TYPE_BURST4);
	assign is_burst8 = (cfg_q.mem_type == SMBT_TYPE_BURST8);

	// classed by the beat after the one now ending, since the count is
	// loaded as a beat finishes; burst-of-four restarts every four beats
	assign beat_nxt = beat_idx_q + 3'h1;
	assign group_start = is_burst4 ? (beat_nxt[1:0] == 2'h0) :
		is_burst8 ? (beat_nxt == 3'h0) : 1'b1;

	// count loaded for the following beat; the address changes with the
	// latch edge so the count is latency minus one
	assign beat_cnt = (group_start || cfg_q.mem_type == SMBT_TYPE_SRAM) ?
		first_eff : next_eff;

	// ************************************************
	// beat completion
	// ************************************************
	// variable-latency beats also wait for the synchronised ready level
	assign strobe_done = (cnt_q == 5'h00) &&
		(!is_var || rdy_sync_q);
	// beats still to go reach zero on the final beat
	assign last_beat = (beats_left_q == 3'h0);
	// a write with every lane masked keeps its strobe parked high
	assign write_masked = (mask_q == SMBT_ALL_MASKED);

	// ************************************************
	// burst address advance
	// ************************************************
	// burst devices wrap inside their burst field, others simply step
	assign addr_step = cfg_q.width16 ? 26'h000_0002 : 26'h000_0004;
	assign addr_wrap = is_burst4 ? (cfg_q.width16 ? 26'h000_0006 : 26'h000_000C) :
		is_burst8 ? (cfg_q.width16 ? 26'h000_000E : 26'h000_001C) :
		26'h3FF_FFFF;
	assign addr_next = (addr_q & ~addr_wrap) |
		((addr_q + addr_step) & addr_wrap);

	// one-hot active-low select for the latched bank
	assign cs_sel_n = ~(6'h01 << bank_q);

	// ************************************************
	// ready input synchroniser
	// ************************************************
	// the first flop feeds only the second
	// a late ready only stretches a beat; it can never shorten one
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdy_meta_q <= 1'b0;
			rdy_sync_q <= 1'b0;
		end else begin
			rdy_meta_q <= io_ready;
			rdy_sync_q <= rdy_meta_q;
		end
	end

	// ************************************************
	// access capture
	// ************************************************
	// request and timing half are frozen for the whole access
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_q <= smbt_half_t'(SMBT_CFG_RESET[15:0]);
			write_q <= 1'b0;
			bank_q <= 3'h0;
			mask_q <= 4'h0;
			wdata_q <= 32'h0000_0000;
		end else if (accept) begin
			cfg_q <= req_half;
			write_q <= req.write;
			bank_q <= req.bank;
			// reads always open every byte lane
			mask_q <= req.write ? req.mask_n : 4'h0;
			wdata_q <= req.wdata;
		end
	end

	// ************************************************
	// sequencer
	// ************************************************
	// strobes and select come from flops; every pin changes on a clock edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= SMBT_IDLE;
			cnt_q <= 5'h00;
			beats_left_q <= 3'h0;
			beat_idx_q <= 3'h0;
			addr_q <= 26'h000_0000;
			ready_q <= 1'b0;
			rd_valid_q <= 1'b0;
			rd_data_q <= 32'h0000_0000;
			cs_n_q <= 6'h3F;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			iowe_n_q <= 1'b1;
			data_oe_q <= 1'b0;
		end else begin
			rd_valid_q <= 1'b0;
			case (state_q)
				SMBT_IDLE: begin
					// ready comes back one clock after the sequencer settles
					ready_q <= 1'b1;
					if (accept) begin
						ready_q <= 1'b0;
						addr_q <= req.addr;
						beat_idx_q <= 3'h0;
						// writes always go out as one beat
						beats_left_q <= req.write ? 3'h0 : req.beats_m1;
						data_oe_q <= req.write;
						// plain reads raise select and strobe together after
						// one address setup clock; others need a lead clock
						cnt_q <= (!req.write && req_half.mem_type != SMBT_TYPE_VARIO) ?
							SMBT_SETUP_SHORT : SMBT_SETUP_LONG;
						state_q <= SMBT_SETUP;
					end
				end
				SMBT_SETUP: begin
					// select is driven here; the strobe joins it once setup runs out
					cs_n_q <= cs_sel_n;
					if (cnt_q != 5'h00) begin
						cnt_q <= cnt_q - 5'h01;
					end else begin
						// first beat: setup clock plus first+1 gives first+2
						cnt_q <= first_eff;
						oe_n_q <= write_q;
						we_n_q <= !(write_q && !is_var && !write_masked);
						iowe_n_q <= !(write_q && is_var && !write_masked);
						state_q <= SMBT_STROBE;
					end
				end
				SMBT_STROBE: begin
					// a beat ends when its count is out and, for io, ready is seen
					if (!strobe_done) begin
						if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
					end else begin
						// data are taken at the edge that ends the beat
						if (!write_q) begin
							rd_valid_q <= 1'b1;
							rd_data_q <= mem_data_i;
						end
						beat_idx_q <= beat_idx_q + 3'h1;
						beats_left_q <= beats_left_q - 3'h1;
						if (last_beat) begin
							oe_n_q <= 1'b1;
							we_n_q <= 1'b1;
							iowe_n_q <= 1'b1;
							state_q <= SMBT_HOLD;
						end else if (is_var) begin
							// variable-latency strobes toggle on every beat
							oe_n_q <= 1'b1;
							cnt_q <= next_eff;
							addr_q <= addr_next;
							state_q <= SMBT_GAP;
						end else begin
							// plain reads keep the strobe low and just move on
							cnt_q <= beat_cnt;
							addr_q <= addr_next;
						end
					end
				end
				SMBT_GAP: begin
					// strobe high for next+1 clocks between beats
					if (cnt_q != 5'h00) begin
						cnt_q <= cnt_q - 5'h01;
					end else begin
						oe_n_q <= 1'b0;
						cnt_q <= first_eff;
						state_q <= SMBT_STROBE;
					end
				end
				SMBT_HOLD: begin
					// select and data held one clock past the strobe
					cs_n_q <= 6'h3F;
					data_oe_q <= 1'b0;
					cnt_q <= recov_cnt;
					state_q <= (recov_cnt == 5'h00) ? SMBT_IDLE : SMBT_RECOV;
				end
				SMBT_RECOV: begin
					// recovery applies after every access; this is stricter
					// than needed for same-bank reads but never too short
					if (cnt_q == 5'h01) state_q <= SMBT_IDLE;
					cnt_q <= cnt_q - 5'h01;
				end
				// unused state codes fall back to idle with selects off
				default: begin
					state_q <= SMBT_IDLE;
					cs_n_q <= 6'h3F;
				end
			endcase
		end
	end

	// ************************************************
	// output drive
	// ************************************************
	// straight from the flops; no logic between them and the pins
	assign req_ready = ready_q;
	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;
	assign memory_address_bus = addr_q;
	assign bank_select_n = cs_n_q;
	assign output_enable_n = oe_n_q;
	assign write_enable_n = we_n_q;
	assign io_write_enable_n = iowe_n_q;
	assign byte_mask_n = mask_q;
	assign mem_data_o = wdata_q;
	assign mem_data_oe = data_oe_q;
endmodule

// ---- verilog/smbt_pkg.sv ----
// shared constants, register map, field layout and carrier types of the
// static memory bank timing block; assumes a 50 MHz ref_clk as memory clock
package smbt_pkg;

	// ************************************************
	// register map (byte addresses)
	// ************************************************
	localparam logic [31:0] SMBT_PAIR01_OFS = 32'h4800_0008;
	localparam logic [31:0] SMBT_PAIR23_OFS = 32'h4800_000C;
	localparam logic [31:0] SMBT_PAIR45_OFS = 32'h4800_0010;
	localparam logic [31:0] SMBT_STATUS_OFS = 32'h4800_0014;
	localparam logic [31:0] SMBT_CFG_RESET = 32'h7FF0_7FF0;
	localparam int SMBT_WIDTH_BIT = 3;
	localparam int SMBT_NUM_PAIRS = 3;

	// ************************************************
	// device type codes and timing counts
	// ************************************************
	localparam logic [2:0] SMBT_TYPE_NONBURST = 3'h0;
	localparam logic [2:0] SMBT_TYPE_SRAM = 3'h1;
	localparam logic [2:0] SMBT_TYPE_BURST4 = 3'h2;
	localparam logic [2:0] SMBT_TYPE_BURST8 = 3'h3;
	localparam logic [2:0] SMBT_TYPE_VARIO = 3'h4;
	localparam logic [4:0] SMBT_SETUP_SHORT = 5'h0;
	localparam logic [4:0] SMBT_SETUP_LONG = 5'h1;
	localparam logic [1:0] SMBT_STRAP_SETTLE = 2'h3;
	localparam logic [3:0] SMBT_ALL_MASKED = 4'hF;

	// sequencer states, gray-coded in the order they are listed
	typedef enum logic [2:0] {
		SMBT_IDLE = 3'b000,
		SMBT_SETUP = 3'b001,
		SMBT_STROBE = 3'b011,
		SMBT_GAP = 3'b010,
		SMBT_HOLD = 3'b110,
		SMBT_RECOV = 3'b111
	} smbt_state_t;

	// one bank half of a pair register, msb first as laid out in the word
	typedef struct packed {
		logic buffering;
		logic [2:0] recovery;
		logic [3:0] next_delay;
		logic [3:0] first_delay;
		logic width16;
		logic [2:0] mem_type;
	} smbt_half_t;

	// one access request from the internal side
	typedef struct packed {
		logic write;
		logic [2:0] bank;
		logic [25:0] addr;
		logic [2:0] beats_m1;
		logic [3:0] mask_n;
		logic [31:0] wdata;
	} smbt_req_t;

	// programmed first-access code to effective memory clocks
	function automatic logic [4:0] smbt_first_delay(input logic [3:0] code);
		logic [4:0] eff;
		eff = {1'b0, code};
		case (code)
			4'hC: eff = 5'h0D;
			4'hD: eff = 5'h0F;
			4'hE: eff = 5'h12;
			4'hF: eff = 5'h17;
			default: eff = {1'b0, code};
		endcase
		return eff;
	endfunction

endpackage

// ---- verilog/smbt_cfg_regs.sv ----
// three bank-pair timing words plus a status word, read data registered
// assumes one-cycle strobes from the register master on ref_clk
`timescale 1ns/1ns
module smbt_cfg_regs
	import smbt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] status_word,
	input wire logic width_strap,
	output logic [31:0] reg_rdata,
	output logic [SMBT_NUM_PAIRS-1:0][31:0] cfg_words
);
	logic [SMBT_NUM_PAIRS-1:0] hit;
	logic [SMBT_NUM_PAIRS-1:0][31:0] cfg_q;
	logic strap_meta_q;
	logic strap_sync_q;
	logic [1:0] settle_q;
	logic strap_load;
	logic hit_status;
	logic [31:0] rd_mux;
	logic [31:0] rdata_q;

	// ************************************************
	// strap capture after reset release
	// ************************************************
	// the strap pin is asynchronous: two flops, then one load of bank 0 width
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			strap_meta_q <= 1'b0;
			strap_sync_q <= 1'b0;
			settle_q <= 2'h0;
		end else begin
			strap_meta_q <= width_strap;
			strap_sync_q <= strap_meta_q;
			if (settle_q != SMBT_STRAP_SETTLE) settle_q <= settle_q + 2'h1;
		end
	end
	assign strap_load = (settle_q == 2'h2);

	// ************************************************
	// pair registers
	// ************************************************
	genvar i;
	generate
		for (i = 0; i < SMBT_NUM_PAIRS; i++) begin : g_pair
			assign hit[i] = (reg_addr == SMBT_PAIR01_OFS + 32'(4 * i));
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					cfg_q[i] <= SMBT_CFG_RESET;
				end else if (reg_wr && hit[i]) begin
					cfg_q[i] <= reg_wdata;
				end else if (i == 0 && strap_load) begin
					cfg_q[i][SMBT_WIDTH_BIT] <= strap_sync_q;
				end
			end
		end
	endgenerate

	// ************************************************
	// read path
	// ************************************************
	// unmapped addresses read as zero
	assign hit_status = (reg_addr == SMBT_STATUS_OFS);
	assign rd_mux = hit[0] ? cfg_q[0] :
		hit[1] ? cfg_q[1] :
		hit[2] ? cfg_q[2] :
		hit_status ? status_word : 32'h0000_0000;

	// read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) rdata_q <= 32'h0000_0000;
		else rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	assign reg_rdata = rdata_q;
	assign cfg_words = cfg_q;
endmodule

// ---- verif/smbt_ctrl_monitor.sv ----
// checker for the bank timing sequencer, fed with top-level ports only
// assumes the pair words change only through the register port
`timescale 1ns/1ns
module smbt_ctrl_monitor
	import smbt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic req_valid,
	input wire smbt_req_t req,
	input wire logic req_ready,
	input wire logic rd_valid,
	input wire logic [25:0] memory_address_bus,
	input wire logic [5:0] bank_select_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic io_write_enable_n,
	input wire logic [3:0] byte_mask_n,
	input wire logic mem_data_oe,
	input wire logic io_ready
);
	// ****
	// shadow state
	// ****
	logic [2:0][31:0] cfg_q;
	smbt_half_t h_q;
	logic [5:0] t_q, gap_q, we_q, st_q, hi_q;
	logic [2:0] beat_q, rec_q;
	// banks 6 and 7 share the last pair
	wire logic [1:0] pr_w = (req.bank[2:1] == 2'h3) ? 2'h2 : req.bank[2:1];
	wire logic [31:0] wd_w = cfg_q[pr_w];
	wire logic sel_w = !(&bank_select_n);
	wire logic vio_w = (h_q.mem_type == SMBT_TYPE_VARIO);
	wire logic b8_w = (h_q.mem_type == SMBT_TYPE_BURST8);
	wire logic bst_w = b8_w || (h_q.mem_type == SMBT_TYPE_BURST4);
	wire logic nx_w = b8_w || (h_q.mem_type == SMBT_TYPE_BURST4 && beat_q[1:0] != 2'h0);
	wire logic [3:0] fc_w = h_q.first_delay;
	// codes above eleven stretch, so the figure is worked out here on its own
	wire logic [5:0] f_w = (fc_w < 4'hC) ? {2'h0, fc_w} :
		fc_w[1] ? (fc_w[0] ? 6'h17 : 6'h12) : (fc_w[0] ? 6'h0F : 6'h0D);
	wire logic [25:0] m4_w = h_q.width16 ? 26'h6 : 26'hC;
	wire logic [25:0] mv_w = b8_w ? (m4_w | {m4_w[24:0], 1'b0}) : m4_w;
	// shadow copies of the pair words
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_q <= {3{SMBT_CFG_RESET}};
		end else if (reg_wr) begin
			for (int i = 0; i < 3; i++) begin
				if (reg_addr == SMBT_PAIR01_OFS + 32'(4 * i)) begin
					cfg_q[i] <= reg_wdata;
				end
			end
		end
	end
	// the half in force is taken when a request is accepted
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			h_q <= '0;
			t_q <= '0;
			beat_q <= '0;
		end else if (req_valid && req_ready) begin
			h_q <= req.bank[0] ? wd_w[31:16] : wd_w[15:0];
			t_q <= 6'h1;
			beat_q <= '0;
		end else begin
			t_q <= (t_q == 6'h3F) ? t_q : t_q + 6'h1;
			beat_q <= beat_q + {2'h0, rd_valid};
		end
	end
	// run lengths of strobes, idle selects and beat spacing
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			we_q <= '0;
			st_q <= '0;
			hi_q <= '0;
			gap_q <= '0;
			rec_q <= '0;
		end else begin
			we_q <= write_enable_n ? 6'h0 : we_q + 6'h1;
			st_q <= (output_enable_n && io_write_enable_n) ? 6'h0 : st_q + 6'h1;
			hi_q <= sel_w ? 6'h0 : (hi_q == 6'h3F ? hi_q : hi_q + 6'h1);
			gap_q <= rd_valid ? 6'h1 : gap_q + 6'h1;
			rec_q <= sel_w ? h_q.recovery : rec_q;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_first_read;
		rd_valid && beat_q == 3'h0 && !vio_w |-> t_q == f_w + 6'h3;
	endproperty
	a_first_read: assert property (p_first_read) else $error("first beat timing");
	property p_next_read;
		rd_valid && beat_q != 3'h0 && !vio_w |->
			gap_q == (nx_w ? {2'h0, h_q.next_delay} + 6'h1 : f_w + 6'h1);
	endproperty
	a_next_read: assert property (p_next_read) else $error("beat spacing");
	property p_write_strobe;
		$rose(write_enable_n) |-> we_q == f_w + 6'h1;
	endproperty
	a_write_strobe: assert property (p_write_strobe) else $error("write strobe length");
	property p_vio_strobe;
		vio_w && ($rose(output_enable_n) || $rose(io_write_enable_n)) |-> st_q >= f_w + 6'h1;
	endproperty
	a_vio_strobe: assert property (p_vio_strobe) else $error("io strobe short");
	property p_ready_sync;
		vio_w && ($rose(output_enable_n) || $rose(io_write_enable_n)) |-> $past(io_ready, 3);
	endproperty
	a_ready_sync: assert property (p_ready_sync) else $error("ended before ready");
	property p_recovery;
		sel_w && $past(!sel_w) |-> hi_q >= {2'h0, rec_q, 1'b0};
	endproperty
	a_recovery: assert property (p_recovery) else $error("select gap short");
	property p_mask_we;
		sel_w && mem_data_oe && byte_mask_n == SMBT_ALL_MASKED |-> write_enable_n && io_write_enable_n;
	endproperty
	a_mask_we: assert property (p_mask_we) else $error("masked beat strobed");
	property p_burst_addr;
		sel_w && $past(sel_w) && bst_w |->
			((memory_address_bus ^ $past(memory_address_bus)) & ~mv_w) == 26'h0;
	endproperty
	a_burst_addr: assert property (p_burst_addr) else $error("burst address");
endmodule

// ---- verif/smbt_mem_model.sv ----
// memory on the far side: answers reads, records writes, paces io ready
// assumes at most one bank is selected at a time
`timescale 1ns/1ns
module smbt_mem_model
	import smbt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [25:0] memory_address_bus,
	input wire logic [5:0] bank_select_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic io_write_enable_n,
	input wire logic [31:0] mem_data_o,
	input wire logic mem_data_oe,
	input wire logic [3:0] wait_cycles,
	output logic [31:0] mem_data_i,
	output logic io_ready,
	output logic [7:0] wr_count,
	output logic [25:0] wr_addr,
	output logic [31:0] wr_data
);
	// ****
	// read drive, ready pacing, write capture
	// ****
	logic [31:0] last_q;
	logic [5:0] wc_q;
	logic wr_q;
	wire logic sel_w = !(&bank_select_n);
	wire logic stb_w = sel_w && !(output_enable_n && io_write_enable_n);
	wire logic wr_w = write_enable_n && io_write_enable_n;
	// a released bus flips every cycle so a late capture cannot pass by luck
	assign mem_data_i = (sel_w && !output_enable_n) ? {6'h2A, memory_address_bus} : ~last_q;
	assign io_ready = stb_w && (wc_q >= {2'h0, wait_cycles});
	// writes are taken as the strobe rises, while address and data still hold
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			last_q <= '0;
			wc_q <= '0;
			wr_q <= 1'b1;
			wr_count <= '0;
			wr_addr <= '0;
			wr_data <= '0;
		end else begin
			last_q <= mem_data_i;
			wc_q <= stb_w ? wc_q + 6'h1 : 6'h0;
			wr_q <= wr_w;
			if (wr_w && !wr_q) begin
				wr_count <= wr_count + 8'h1;
				wr_addr <= memory_address_bus;
				wr_data <= mem_data_oe ? mem_data_o : ~mem_data_o;
			end
		end
	end
endmodule

// ---- verif/static_memory_bank_timing_tb_top.sv ----
// bench for the bank timing sequencer: register port and access tasks
// assumes the memory model and the monitor are compiled before this file
`timescale 1ns/1ns
module static_memory_bank_timing_tb_top
	import smbt_pkg::*;
;
	// ****
	// stimulus and checks
	// ****
	localparam logic [25:0] ALL = 26'h3FF_FFFF;
	localparam logic [31:0] CFG [3] = '{32'h2129_11C0, 32'h124B_1132, 32'h00F5_1224};
	logic ref_clk, rst, reg_wr, reg_rd, req_valid, req_ready, rd_valid, width_strap, io_ready;
	logic output_enable_n, write_enable_n, io_write_enable_n, mem_data_oe;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, rd_data, mem_data_o, mem_data_i, wr_data, got;
	logic [25:0] memory_address_bus, wr_addr;
	logic [5:0] bank_select_n;
	logic [3:0] byte_mask_n, wait_cycles;
	logic [7:0] wr_count;
	smbt_req_t req;
	logic [31:0] rd_q[$];
	int fail_count, tests_run;
	smbt_ctrl dut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid,
		.req, .req_ready, .rd_valid, .rd_data, .memory_address_bus, .bank_select_n,
		.output_enable_n, .write_enable_n, .io_write_enable_n, .byte_mask_n, .mem_data_o,
		.mem_data_oe, .mem_data_i, .io_ready, .width_strap);
	smbt_mem_model u_mem (.ref_clk, .rst, .memory_address_bus, .bank_select_n, .output_enable_n,
		.write_enable_n, .io_write_enable_n, .mem_data_o, .mem_data_oe, .wait_cycles,
		.mem_data_i, .io_ready, .wr_count, .wr_addr, .wr_data);
	// free-running 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic check32(input logic [31:0] g, input logic [31:0] e, input string what);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask
	task automatic reg_write(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [31:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
	// request held until taken, then beats gathered until the sequencer is idle again
	task automatic access(input logic w, input logic [2:0] b, input logic [25:0] a,
		input logic [2:0] n, input logic [3:0] m);
		int k;
		rd_q = {};
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req <= '{write: w, bank: b, addr: a, beats_m1: n, mask_n: m, wdata: {6'h15, a}};
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (req_ready !== 1'b1 && k < 400);
		req_valid <= 1'b0;
		do begin
			@(posedge ref_clk);
			k++;
			if (rd_valid === 1'b1) rd_q.push_back(rd_data);
		end while (req_ready !== 1'b1 && k < 800);
		check32(32'(k < 800), 32'h1, "access finished");
	endtask
	task automatic rd_test(input logic [2:0] b, input logic [25:0] a, input logic [2:0] n,
		input logic [25:0] st, input logic [25:0] wm);
		logic [25:0] e;
		access(1'b0, b, a, n, 4'h0);
		check32(rd_q.size(), n + 32'h1, "beat count");
		for (int i = 0; i < rd_q.size(); i++) begin
			e = (a & ~wm) | ((a + st * i) & wm);
			check32(rd_q[i], {6'h2A, e}, "read data");
		end
	endtask
	task automatic wr_test(input logic [2:0] b, input logic [25:0] a, input logic [3:0] m,
		input logic [7:0] inc);
		logic [7:0] c0;
		c0 = wr_count;
		access(1'b1, b, a, 3'h3, m);
		check32(wr_count, c0 + inc, "write count");
		check32(byte_mask_n, m, "byte mask");
		if (inc != 8'h0) begin
			check32(wr_addr, a, "write address");
			check32(wr_data, {6'h15, a}, "write data");
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// a hang far beyond the few hundred cycles of the run ends it as a failure
	initial begin
		#1000000;
		fail_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		results();
	end
	// main sequence
	initial begin
		{rst, reg_wr, reg_rd, req_valid, width_strap} = 5'h10;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		req = '0;
		wait_cycles = 4'h0;
		fail_count = 0;
		tests_run = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (5) @(posedge ref_clk);
		for (int i = 0; i < 3; i++) begin
			reg_read(SMBT_PAIR01_OFS + 32'(4 * i), got);
			check32(got, SMBT_CFG_RESET, "reset word");
		end
		reg_write(32'h4800_0020, 32'hFFFF_FFFF);
		reg_read(32'h4800_0020, got);
		check32(got, 32'h0, "unmapped");
		for (int i = 0; i < 3; i++) begin
			reg_write(SMBT_PAIR01_OFS + 32'(4 * i), CFG[i]);
			reg_read(SMBT_PAIR01_OFS + 32'(4 * i), got);
			check32(got, CFG[i], "pair word");
		end
		$display("test registers done");
		rd_test(3'h0, 26'h100, 3'h1, 26'h4, ALL);
		rd_test(3'h1, 26'h40, 3'h1, 26'h2, ALL);
		rd_test(3'h2, 26'h8, 3'h4, 26'h4, 26'hF);
		rd_test(3'h3, 26'h6, 3'h7, 26'h2, 26'hF);
		rd_test(3'h5, 26'h80, 3'h0, 26'h4, ALL);
		wait_cycles <= 4'h3;
		rd_test(3'h4, 26'h20, 3'h1, 26'h4, ALL);
		$display("test reads done");
		wr_test(3'h0, 26'h200, 4'h0, 8'h1);
		wr_test(3'h1, 26'h44, 4'hF, 8'h0);
		wr_test(3'h4, 26'h24, 4'h0, 8'h1);
		$display("test writes done");
		// the timing word is rewritten while a read is under way
		fork
			rd_test(3'h0, 26'h300, 3'h0, 26'h4, ALL);
			begin
				repeat (4) @(posedge ref_clk);
				reg_write(SMBT_PAIR01_OFS, 32'h2129_11F0);
			end
		join
		rd_test(3'h0, 26'h304, 3'h0, 26'h4, ALL);
		$display("test latching done");
		results();
	end
endmodule
bind smbt_ctrl smbt_ctrl_monitor u_mon (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
	.req_valid, .req, .req_ready, .rd_valid, .memory_address_bus, .bank_select_n,
	.output_enable_n, .write_enable_n, .io_write_enable_n, .byte_mask_n, .mem_data_oe,
	.io_ready);
